// [verif/clear_osc_model.sv]
`timescale 1ns/10ps
module clear_osc_model #(
  parameter int HOLD = 8
) (
  // Clock
  input  wire logic clk,
  // Requests from bench
  input  wire logic clear_req,
  input  wire logic osc_run,
  // Pins toward the block
  output logic      master_clear_pin_n = 1'b1,
  output logic      osc_tick = 1'b0,
  output logic      clock_valid
);
  int hold_cnt = 0;
  always @(posedge clk) begin
    if (clear_req) hold_cnt <= HOLD;
    else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
    master_clear_pin_n <= !clear_req && hold_cnt == 0;
  end
  // Oscillator stands still when stopped
  always @(posedge clk) begin
    osc_tick <= osc_run ? !osc_tick : 1'b0;
  end
  assign clock_valid = osc_run;
endmodule : clear_osc_model

// [verif/tb_reset_delay_sequencer.sv]
`timescale 1ns/10ps
module tb_reset_delay_sequencer;
  localparam int SU = 50;
  localparam int ST = rst_seq_pkg::STATE_RESET_CYC;
  localparam int OS = 2 * rst_seq_pkg::OSC_START_PERIODS;
  localparam int LK = rst_seq_pkg::PLL_LOCK_CYC;
  localparam int SR = rst_seq_pkg::STARTUP_REG_CYC;
  typedef struct {
    rst_seq_pkg::rst_cause_s c;
    logic                    wake;
    logic                    pin;
    rst_seq_pkg::clk_src_e   src;
    logic                    reg_en;
    int                      rst;
    int                      clk_d;
    int                      mon;
  } row_s;
  logic                     clk;
  logic                     rst_n = 1'b0;
  rst_seq_pkg::rst_cause_s  cause = '0;
  logic                     wake_from_sleep = 1'b0;
  rst_seq_pkg::clk_src_e    clk_src = rst_seq_pkg::fast_rc_source;
  logic                     regulator_en = 1'b0;
  logic                     osc_run = 1'b1;
  logic                     monitor_en = 1'b1;
  logic                     clear_req = 1'b0;
  logic                     pin_n;
  logic                     osc_tick;
  logic                     clock_valid;
  rst_seq_pkg::seq_status_s status;
  row_s                     rows[9];
  int                       num_errors = 0;
  int                       tests_run = 0;
  int                       n;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  reset_delay_sequencer #(.STARTUP_NOREG_CYCLES(SU)) dut (
    .clk(clk), .rst_n(rst_n), .master_clear_pin_n(pin_n),
    .cause(cause), .wake_from_sleep(wake_from_sleep),
    .clk_src(clk_src), .regulator_en(regulator_en),
    .monitor_en(monitor_en), .osc_tick(osc_tick),
    .clock_valid(clock_valid), .status(status));

  clear_osc_model far (.clk(clk), .clear_req(clear_req),
    .osc_run(osc_run), .master_clear_pin_n(pin_n),
    .osc_tick(osc_tick), .clock_valid(clock_valid));

  task automatic check(input string nm, input int e, input int g);
    tests_run++;
    if (g < e - 8 || g > e + 8) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check

  task automatic check_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  function automatic logic pick(input int w);
    if (w == 0) return !status.internal_system_reset;
    if (w == 1) return status.clock_released;
    return status.clock_fail_monitor_on;
  endfunction : pick

  task automatic wait_for(input int w, output int k);
    k = 0;
    while (pick(w) !== 1'b1 && k < 40000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_for

  task automatic pulse(input row_s r);
    @(posedge clk);
    clk_src <= r.src;
    regulator_en <= r.reg_en;
    @(posedge clk);
    cause <= r.c;
    wake_from_sleep <= r.wake;
    clear_req <= r.pin;
    @(posedge clk);
    cause <= '0;
    wake_from_sleep <= 1'b0;
    clear_req <= 1'b0;
  endtask : pulse

  task automatic run_row(input row_s r);
    pulse(r);
    // Pin goes through model and synchroniser
    if (r.pin) repeat (3) @(posedge clk);
    #1;
    check_bit("internal_system_reset_on", 1'b1, status.internal_system_reset);
    wait_for(0, n);
    check("internal_system_reset_len", r.rst, n);
    check_bit("run_early", r.clk_d == 0, status.run_enable);
    wait_for(1, n);
    check("clk_delay", r.clk_d, n);
    check_bit("monitor", r.mon == 0, status.clock_fail_monitor_on);
    if (r.mon == 1) begin
      wait_for(2, n);
      check("mon_delay", rst_seq_pkg::MONITOR_CYC, n);
    end
  endtask : run_row

  task automatic results();
    $display("Checks: %0d, errors: %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  initial begin
    repeat (120000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    rows = '{
      '{8'h40, 0, 0, rst_seq_pkg::crystal_high_speed_with_pll, 0,
        SU + ST, OS + LK, 1},
      '{8'h80, 0, 0, rst_seq_pkg::crystal_medium_source, 0,
        rst_seq_pkg::POR_CYC + SU + ST, OS, 2},
      '{8'h00, 1, 0, rst_seq_pkg::external_clock_source, 1,
        SR + ST, 0, 0},
      '{8'h10, 0, 0, rst_seq_pkg::fast_rc_with_pll, 0, ST, 0, 0},
      '{8'h08, 0, 0, rst_seq_pkg::crystal_medium_with_pll, 0, ST, 0, 0},
      '{8'h04, 0, 0, rst_seq_pkg::secondary_osc_source, 0, ST, 0, 0},
      '{8'h02, 0, 0, rst_seq_pkg::low_power_rc_source, 0, ST, 0, 0},
      '{8'h01, 0, 0, rst_seq_pkg::fast_rc_source, 0, ST, 0, 0},
      '{8'h00, 0, 1, rst_seq_pkg::external_clock_with_pll, 0,
        ST + 8, 0, 0}};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Each cause row in turn; the first, a brown-out, lands inside the power-on sequence
    foreach (rows[i]) run_row(rows[i]);
    // Wake start-up cut short by a trap reset
    pulse(rows[2]);
    repeat (100) @(posedge clk);
    run_row(rows[7]);
    // Second power-on through rst_n, plain source
    @(posedge clk);
    rst_n <= 1'b0;
    clk_src <= rst_seq_pkg::fast_rc_source;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check_bit("por_hold", 1'b1, status.internal_system_reset);
    wait_for(0, n);
    check("por_len", rst_seq_pkg::POR_CYC + SU + ST, n);
    // Clock lost with monitor off, then on
    @(posedge clk);
    monitor_en <= 1'b0;
    osc_run <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check_bit("no_switch", 1'b0, status.switch_to_fast_rc);
    @(posedge clk);
    monitor_en <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check_bit("to_fast_rc", 1'b1, status.switch_to_fast_rc);
    check_bit("run_on_rc", 1'b1, status.run_enable);
    results();
  end
endmodule : tb_reset_delay_sequencer

// [verilog/osc_start_timer.sv]
`timescale 1ns/10ps
module osc_start_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic restart,
  input  wire logic osc_tick,
  // Result
  output logic      expired
);

  logic [rst_seq_pkg::OSC_CNT_W-1:0] cnt_reg;
  logic                              done_reg;

  // Ten-bit period counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (restart) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (osc_tick && !done_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
      if (&cnt_reg) begin
        done_reg <= 1'b1;
      end
    end
  end

  assign expired = done_reg;

endmodule : osc_start_timer

// [verilog/reset_delay_sequencer.sv]
`timescale 1ns/10ps
module reset_delay_sequencer #(
  parameter int unsigned STARTUP_NOREG_CYCLES =
    rst_seq_pkg::STARTUP_NOREG_CYC
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Reset causes and pins
  input  wire logic                    master_clear_pin_n,
  input  rst_seq_pkg::rst_cause_s      cause,
  input  wire logic                    wake_from_sleep,
  // Configuration
  input  rst_seq_pkg::clk_src_e        clk_src,
  input  wire logic                    regulator_en,
  input  wire logic                    monitor_en,
  // Oscillator side
  input  wire logic                    osc_tick,
  input  wire logic                    clock_valid,
  // Status
  output rst_seq_pkg::seq_status_s     status
);

  typedef enum logic [2:0] {
    st_por, st_startup, st_state_rst, st_clk_wait, st_monitor, st_run
  } seq_e;

  seq_e              state_reg;
  logic [rst_seq_pkg::CNT_W-1:0] cnt_reg;
  logic              full_seq_reg;
  logic              master_clear_pin_s1_reg, master_clear_pin_s2_reg;
  logic              osc_s1_reg, osc_s2_reg, osc_prev_reg;
  logic              cv_s1_reg, cv_s2_reg;
  logic              lock_done_reg;
  logic              fail_switch_reg;
  logic              osc_restart;
  logic              osc_done;
  logic              master_clear_pin_evt;
  logic              long_evt, short_evt;
  logic              need_osc, need_lock, need_mon;
  logic [rst_seq_pkg::CNT_W-1:0] startup_cyc;

  function automatic logic [rst_seq_pkg::CNT_W-1:0] cyc(
    input int unsigned n
  );
    cyc = rst_seq_pkg::CNT_W'(n - 1);
  endfunction : cyc

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_s1_reg   <= 1'b1;
      master_clear_pin_s2_reg   <= 1'b1;
      osc_s1_reg    <= 1'b0;
      osc_s2_reg    <= 1'b0;
      osc_prev_reg  <= 1'b0;
      cv_s1_reg     <= 1'b0;
      cv_s2_reg     <= 1'b0;
    end else begin
      master_clear_pin_s1_reg   <= master_clear_pin_n;
      master_clear_pin_s2_reg   <= master_clear_pin_s1_reg;
      osc_s1_reg    <= osc_tick;
      osc_s2_reg    <= osc_s1_reg;
      osc_prev_reg  <= osc_s2_reg;
      cv_s1_reg     <= clock_valid;
      cv_s2_reg     <= cv_s1_reg;
    end
  end

  assign master_clear_pin_evt  = !master_clear_pin_s2_reg;
  assign long_evt  = cause.power_on || cause.brown_out_reset ||
                     wake_from_sleep;
  assign short_evt = master_clear_pin_evt || cause.master_clear ||
                     cause.watchdog_timeout_reset || cause.software ||
                     cause.illegal_opcode || cause.uninit_wreg ||
                     cause.trap_conflict;

  assign need_lock = clk_src inside {rst_seq_pkg::external_clock_with_pll,
    rst_seq_pkg::fast_rc_with_pll, rst_seq_pkg::crystal_medium_with_pll,
    rst_seq_pkg::crystal_high_speed_with_pll};
  assign need_osc = clk_src inside {rst_seq_pkg::crystal_medium_source,
    rst_seq_pkg::crystal_high_speed_source,
    rst_seq_pkg::secondary_osc_source,
    rst_seq_pkg::crystal_medium_with_pll,
    rst_seq_pkg::crystal_high_speed_with_pll};
  assign need_mon = need_lock || need_osc;

  assign startup_cyc = regulator_en ? cyc(rst_seq_pkg::STARTUP_REG_CYC)
                                    : cyc(STARTUP_NOREG_CYCLES);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= st_por;
      cnt_reg      <= rst_seq_pkg::CNT_W'(rst_seq_pkg::POR_CYC - 1);
      full_seq_reg <= 1'b1;
    end else if (cause.power_on) begin
      state_reg    <= st_por;
      cnt_reg      <= cyc(rst_seq_pkg::POR_CYC);
      full_seq_reg <= 1'b1;
    end else if (cause.brown_out_reset ||
                 (wake_from_sleep && regulator_en)) begin
      state_reg    <= st_startup;
      cnt_reg      <= startup_cyc;
      full_seq_reg <= 1'b1;
    end else if (short_evt || wake_from_sleep) begin
      state_reg    <= st_state_rst;
      cnt_reg      <= cyc(rst_seq_pkg::STATE_RESET_CYC);
      full_seq_reg <= 1'b0;
    end else begin
      case (state_reg)
        st_por: begin
          if (cnt_reg == '0) begin
            state_reg <= st_startup;
            cnt_reg   <= startup_cyc;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        st_startup: begin
          if (cnt_reg == '0) begin
            state_reg <= st_state_rst;
            cnt_reg   <= cyc(rst_seq_pkg::STATE_RESET_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        st_state_rst: begin
          if (cnt_reg == '0) begin
            state_reg <= (full_seq_reg && need_mon) ? st_clk_wait : st_run;
            cnt_reg   <= cyc(rst_seq_pkg::PLL_LOCK_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        st_clk_wait: begin
          if (cnt_reg != '0 && (!need_osc || osc_done)) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
          if ((!need_lock || lock_done_reg) && (!need_osc || osc_done)) begin
            state_reg <= st_monitor;
            cnt_reg   <= cyc(rst_seq_pkg::MONITOR_CYC);
          end
        end
        st_monitor: begin
          if (cnt_reg == '0) begin
            state_reg <= st_run;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        st_run: cnt_reg <= '0;
        default: state_reg <= st_por;
      endcase
    end
  end

  // Lock interval flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_done_reg <= 1'b0;
    end else if (state_reg != st_clk_wait) begin
      lock_done_reg <= 1'b0;
    end else if (cnt_reg == '0) begin
      lock_done_reg <= 1'b1;
    end
  end

  assign osc_restart = state_reg != st_clk_wait;

  osc_start_timer u_ost (
    .clk      (clk),
    .rst_n    (rst_n),
    .restart  (osc_restart),
    .osc_tick (osc_s2_reg && !osc_prev_reg),
    .expired  (osc_done)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_switch_reg <= 1'b0;
    end else if (state_reg != st_run) begin
      fail_switch_reg <= 1'b0;
    end else if (monitor_en && !cv_s2_reg) begin
      fail_switch_reg <= 1'b1;
    end
  end

  always_comb begin
    status.internal_system_reset = state_reg inside {st_por, st_startup,
                                                     st_state_rst};
    status.clock_released = state_reg inside {st_monitor, st_run};
    status.run_enable = status.clock_released &&
                        (cv_s2_reg || fail_switch_reg);
    status.clock_fail_monitor_on = monitor_en && state_reg == st_run;
    status.switch_to_fast_rc = fail_switch_reg;
  end

  property p_short_len;
    @(posedge clk) disable iff (!rst_n)
    (cause.software && !cause.power_on && !cause.brown_out_reset &&
     !wake_from_sleep) |=> state_reg == st_state_rst &&
     cnt_reg == cyc(rst_seq_pkg::STATE_RESET_CYC);
  endproperty
  a_short_len: assert property (p_short_len)
    else $error("short reset did not load state reset time");

  property p_por_start;
    @(posedge clk) disable iff (!rst_n)
    cause.power_on |=> state_reg == st_por;
  endproperty
  a_por_start: assert property (p_por_start)
    else $error("power-on did not start por delay");

  property p_run_clk;
    @(posedge clk) disable iff (!rst_n)
    status.run_enable |-> status.clock_released &&
                          !status.internal_system_reset;
  endproperty
  a_run_clk: assert property (p_run_clk)
    else $error("run before clock released");

  property p_master_clear_pin_hold;
    @(posedge clk) disable iff (!rst_n)
    (master_clear_pin_evt && !long_evt) |=> state_reg == st_state_rst &&
     cnt_reg == cyc(rst_seq_pkg::STATE_RESET_CYC);
  endproperty
  a_master_clear_pin_hold: assert property (p_master_clear_pin_hold)
    else $error("master clear did not reload state reset time");

  property p_plain_run;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == st_state_rst && cnt_reg == '0 && !need_mon &&
     !long_evt && !short_evt) |=> state_reg == st_run;
  endproperty
  a_plain_run: assert property (p_plain_run)
    else $error("plain source did not go straight to run");

  property p_fast_rc;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == st_run && monitor_en && !cv_s2_reg && !long_evt &&
     !short_evt) |=> status.switch_to_fast_rc;
  endproperty
  a_fast_rc: assert property (p_fast_rc)
    else $error("lost clock did not switch to fast rc");

  c_run: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == st_monitor ##1 state_reg == st_run);
  c_fail: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(fail_switch_reg));
  c_master_clear_pin: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(master_clear_pin_s2_reg));

endmodule : reset_delay_sequencer

// [verilog/rst_seq_pkg.sv]
package rst_seq_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Nominal delay times
  localparam int unsigned POR_DELAY_US      = 10;
  localparam int unsigned STARTUP_REG_US    = 20;
  localparam int unsigned STARTUP_NOREG_MS  = 64;
  localparam int unsigned STATE_RESET_US    = 20;
  localparam int unsigned PLL_LOCK_US       = 20;
  localparam int unsigned MONITOR_DELAY_US  = 100;
  localparam int unsigned OSC_START_PERIODS = 1024;
  localparam int unsigned OSC_CNT_W         = 10;

  // Derived cycle counts, rounded down
  localparam int unsigned POR_CYC =
    POR_DELAY_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned STARTUP_REG_CYC =
    STARTUP_REG_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned STARTUP_NOREG_CYC =
    STARTUP_NOREG_MS * 1000 * (1000000 / CLK_PERIOD_PS);
  localparam int unsigned STATE_RESET_CYC =
    STATE_RESET_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned PLL_LOCK_CYC =
    PLL_LOCK_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned MONITOR_CYC =
    MONITOR_DELAY_US * 1000000 / CLK_PERIOD_PS;

  localparam int unsigned CNT_W = 25;

  // Clock source selection
  typedef enum logic [3:0] {
    external_clock_source,
    fast_rc_source,
    low_power_rc_source,
    crystal_medium_source,
    crystal_high_speed_source,
    secondary_osc_source,
    external_clock_with_pll,
    fast_rc_with_pll,
    crystal_medium_with_pll,
    crystal_high_speed_with_pll
  } clk_src_e;

  // Reset cause pulses
  typedef struct packed {
    logic power_on;
    logic brown_out_reset;
    logic master_clear;
    logic watchdog_timeout_reset;
    logic software;
    logic illegal_opcode;
    logic uninit_wreg;
    logic trap_conflict;
  } rst_cause_s;

  // Status toward the core
  typedef struct packed {
    logic internal_system_reset;
    logic clock_released;
    logic run_enable;
    logic clock_fail_monitor_on;
    logic switch_to_fast_rc;
  } seq_status_s;

endpackage : rst_seq_pkg
